/* File: verilog/u1_map.svh */
// register map, field positions, reset values and divider ratios of the serial port
// assumes a 32-bit apb slave decoding paddr[7:0]; included by its bare name
`ifndef U1_MAP_SVH
`define U1_MAP_SVH

// register byte offsets
`define U1_OFS_DATA   8'h00
`define U1_OFS_SCS    8'h04
`define U1_OFS_FMT    8'h08
`define U1_OFS_BGC    8'h0c
`define U1_OFS_RLH    8'h10
`define U1_OFS_RLL    8'h14

// serial_control_status bit positions
`define U1_SCS_RI     0
`define U1_SCS_TI     1
`define U1_SCS_THRE   2
`define U1_SCS_TBX    3
`define U1_SCS_REN    4
`define U1_SCS_IE     5
`define U1_SCS_OVR    6

// baud_gen_control: enable bit, prescale select in [1:0]
`define U1_BGC_EN     6
`define U1_PS_12      2'b00
`define U1_PS_4       2'b01
`define U1_PS_48      2'b10
`define U1_PS_1       2'b11
`define U1_DIV_1      6'h01
`define U1_DIV_4      6'h04
`define U1_DIV_12     6'h0c
`define U1_DIV_48     6'h30

// reset values and counts
`define U1_RST_RELOAD 16'h0000
`define U1_RST_FMT    7'h03
`define U1_TMR_MAX    16'hffff
`define U1_LEN_BASE   3'h4

`endif

/* File: verilog/u1_pkg.sv */
// types shared by the serial port design files
// assumes the map header supplies all numeric constants
package u1_pkg;

  // frame format, laid out as the format register
  typedef struct packed {
    logic       sb2;
    logic       xbe;
    logic [1:0] ptype;
    logic       pe;
    logic [1:0] len;
  } u1_fmt_type;

  // baud generator configuration
  typedef struct packed {
    logic        en;
    logic [1:0]  ps;
    logic [15:0] reload;
  } u1_bcfg_type;

  typedef enum logic [2:0] {TX_IDLE, TX_SYNC, TX_START, TX_DATA, TX_EXTRA, TX_STOP} u1_tx_st_type;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_EXTRA, RX_STOP} u1_rx_st_type;

endpackage

/* File: verilog/u1_baud.sv */
// baud generator: prescaler and 16-bit up-counting reload timer
// assumes configuration comes from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "u1_map.svh"

module u1_baud
  import u1_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // configuration and overflow strobe
  input  wire u1_bcfg_type cfg,
  output logic             ovf
);

  logic [5:0]  pcnt_ff, nxt_pcnt;
  logic [15:0] tmr_ff, nxt_tmr;
  logic [5:0]  div;
  logic        tick;

  always_comb begin
    unique case (cfg.ps)
      `U1_PS_1:  div = `U1_DIV_1;
      `U1_PS_4:  div = `U1_DIV_4;
      `U1_PS_12: div = `U1_DIV_12;
      `U1_PS_48: div = `U1_DIV_48;
    endcase
  end

  // >= so a ratio change mid-count cannot run the prescaler past its end
  assign tick = cfg.en && (pcnt_ff >= div - 6'h01);
  assign ovf  = tick && (tmr_ff == `U1_TMR_MAX);

  always_comb begin
    nxt_pcnt = pcnt_ff;
    nxt_tmr  = tmr_ff;
    if (!cfg.en) begin
      nxt_pcnt = 6'h00;
      nxt_tmr  = cfg.reload;
    end else if (tick) begin
      nxt_pcnt = 6'h00;
      nxt_tmr  = ovf ? cfg.reload : tmr_ff + 16'h0001;
    end else begin
      nxt_pcnt = pcnt_ff + 6'h01;
    end
  end

  // timer registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pcnt_ff <= 6'h00;
      tmr_ff  <= `U1_RST_RELOAD;
    end else begin
      pcnt_ff <= nxt_pcnt;
      tmr_ff  <= nxt_tmr;
    end
  end

  property p_reload;
    @(posedge mclk) disable iff (!nrst)
    ovf |=> tmr_ff == $past(cfg.reload);
  endproperty
  a_reload: assert property (p_reload) else $error("timer did not reload on wrap");

  property p_inc;
    @(posedge mclk) disable iff (!nrst)
    tick && !ovf |=> tmr_ff == $past(tmr_ff) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("timer did not step by one");

  property p_hold;
    @(posedge mclk) disable iff (!nrst)
    !cfg.en |=> tmr_ff == $past(cfg.reload) && pcnt_ff == 6'h00;
  endproperty
  a_hold: assert property (p_hold) else $error("disabled timer not preloaded");

endmodule // u1_baud
`default_nettype wire

/* File: verilog/u1_rxfifo.sv */
// receive fifo: small circular buffer with head presented at the output
// assumes push is never given while full and pop never while empty
`timescale 1ns/1ps
`default_nettype none

module u1_rxfifo #(
  parameter int W  = 8,
  parameter int D  = 3,
  parameter int CW = $clog2(D + 1),
  parameter int PW = $clog2(D)
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          nrst,
  // fill and drain
  input  wire logic          push,
  input  wire logic [W-1:0]  din,
  input  wire logic          pop,
  output logic [W-1:0]       dout,
  // occupancy
  output logic [CW-1:0]      cnt,
  output logic               full,
  output logic               empty
);

  logic [W-1:0]  mem_ff [D];
  logic [PW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [CW-1:0] cnt_ff, nxt_cnt;

  // pointers wrap at the depth, which need not be a power of two
  always_comb begin
    nxt_wp  = wp_ff;
    nxt_rp  = rp_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_wp = (wp_ff == PW'(D - 1)) ? '0 : wp_ff + PW'(1);
    end
    if (pop) begin
      nxt_rp = (rp_ff == PW'(D - 1)) ? '0 : rp_ff + PW'(1);
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + CW'(1);
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - CW'(1);
    end
  end

  // pointer and count registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // storage needs no reset; unread slots are never shown
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wp_ff] <= din;
    end
  end

  assign dout  = empty ? '0 : mem_ff[rp_ff];
  assign cnt   = cnt_ff;
  assign full  = (cnt_ff == CW'(D));
  assign empty = (cnt_ff == '0);

endmodule // u1_rxfifo
`default_nettype wire

/* File: verilog/u1_top.sv */
// serial port with apb registers, baud generator and three-byte receive fifo
// assumes an apb master on mclk and an asynchronous serial partner on uart_rx/uart_tx
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "u1_map.svh"

// Overview of operation
// - writes to the data port go only to the transmit holding register
// - data port reads return oldest fifo byte; holding register is never readable
// - receiver buffers up to three bytes before overflow
// - with interrupt enabled, tx-done or rx-ready raises an interrupt request
// - flags stay set until software clears them explicitly
// - clearing rx-ready is ignored while more bytes wait in the fifo
// - transmitter and receiver run independently at the same time
// - bit timing comes from a private 16-bit timer behind a prescaler
// - prescaler divides by 1, 4, 12 or 48
// - baud control register holds enable and prescale select
// - no transfer while the baud generator is disabled
// - 16-bit reload value split in readable, writable high and low bytes
// - timer increments once per prescaled tick from the reload value
// - on wrap from maximum the timer reloads in the same step
// - bit rate is clock / prescaler / (65536 - reload) / 2
// - frame is start low, 5-8 bits lsb first, optional extra, 1-2 stop
// - byte moves to shifter when idle; tx-done rises at stop bit start
// - byte stored only if enabled, fifo not full, stop high; full sets overrun
// - reading the data port presents the next byte and frees its slot
module u1_top
  import u1_pkg::*;
#(
  parameter int FIFO_DEPTH = 3
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line
  input  wire logic        uart_rx,
  output logic             uart_tx,
  // interrupt request
  output logic             irq
);

  localparam int CW = $clog2(FIFO_DEPTH + 1);

  logic          rx_m_ff, rx_s_ff;
  logic          pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic [31:0]   prdata_ff, nxt_prdata, rval;
  logic          hit, acc, done, wr, rd, wr_scs;
  logic          ren_ff, nxt_ren, ie_ff, nxt_ie, tbx_ff, nxt_tbx;
  u1_fmt_type    fmt_ff, nxt_fmt;
  u1_bcfg_type   bcfg_ff, nxt_bcfg;
  logic          ri_ff, nxt_ri, ti_ff, nxt_ti, ovr_ff, nxt_ovr, irq_ff, nxt_irq;
  logic [7:0]    thr_ff, nxt_thr;
  logic          thr_full_ff, nxt_thr_full;
  u1_tx_st_type  tx_st_ff, nxt_tx_st;
  logic [7:0]    tx_sh_ff, nxt_tx_sh, msk;
  logic [2:0]    tx_cnt_ff, nxt_tx_cnt, last;
  logic          tx_ph_ff, nxt_tx_ph, tx_ff, nxt_tx, eb_ff, nxt_eb, tx_load, ti_set;
  u1_rx_st_type  rx_st_ff, nxt_rx_st;
  logic [7:0]    rx_sh_ff, nxt_rx_sh;
  logic [2:0]    rx_cnt_ff, nxt_rx_cnt;
  logic          rx_ph_ff, nxt_rx_ph, rx_fin, push, pop, ovr_set;
  logic          ovf, f_full, f_empty;
  logic [7:0]    f_head;
  logic [CW-1:0] f_cnt;

  // serial input crosses into mclk through two flops
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_m_ff <= 1'b1;
      rx_s_ff <= 1'b1;
    end else begin
      rx_m_ff <= uart_rx;
      rx_s_ff <= rx_m_ff;
    end
  end

  assign acc    = psel && penable;
  assign done   = acc && pready_ff;
  assign wr     = done && pwrite && hit;
  assign rd     = done && !pwrite && hit;
  assign wr_scs = wr && (paddr == `U1_OFS_SCS);
  assign last   = 3'(fmt_ff.len) + `U1_LEN_BASE;

  // read mux and address decode
  always_comb begin
    rval = 32'h0000_0000;
    hit  = 1'b1;
    unique case (paddr)
      `U1_OFS_DATA: rval[7:0] = f_head;
      `U1_OFS_SCS: begin
        rval[`U1_SCS_RI]   = ri_ff;
        rval[`U1_SCS_TI]   = ti_ff;
        rval[`U1_SCS_THRE] = !thr_full_ff;
        rval[`U1_SCS_TBX]  = tbx_ff;
        rval[`U1_SCS_REN]  = ren_ff;
        rval[`U1_SCS_IE]   = ie_ff;
        rval[`U1_SCS_OVR]  = ovr_ff;
      end
      `U1_OFS_FMT: rval[6:0] = fmt_ff;
      `U1_OFS_BGC: begin
        rval[`U1_BGC_EN] = bcfg_ff.en;
        rval[1:0]        = bcfg_ff.ps;
      end
      `U1_OFS_RLH: rval[7:0] = bcfg_ff.reload[15:8];
      `U1_OFS_RLL: rval[7:0] = bcfg_ff.reload[7:0];
      default:     hit = 1'b0;
    endcase
  end

  // one wait state: answer is prepared in the first access cycle
  always_comb begin
    nxt_pready  = acc && !pready_ff;
    nxt_pslverr = acc && !pready_ff && !hit;
    nxt_prdata  = (acc && !pready_ff && !pwrite) ? rval : prdata_ff;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  // software configuration registers
  always_comb begin
    nxt_ren  = ren_ff;
    nxt_ie   = ie_ff;
    nxt_tbx  = tbx_ff;
    nxt_fmt  = fmt_ff;
    nxt_bcfg = bcfg_ff;
    if (wr_scs) begin
      nxt_ren = pwdata[`U1_SCS_REN];
      nxt_ie  = pwdata[`U1_SCS_IE];
      nxt_tbx = pwdata[`U1_SCS_TBX];
    end
    if (wr && paddr == `U1_OFS_FMT) begin
      nxt_fmt = u1_fmt_type'(pwdata[6:0]);
    end
    if (wr && paddr == `U1_OFS_BGC) begin
      nxt_bcfg.en = pwdata[`U1_BGC_EN];
      nxt_bcfg.ps = pwdata[1:0];
    end
    if (wr && paddr == `U1_OFS_RLH) begin
      nxt_bcfg.reload[15:8] = pwdata[7:0];
    end
    if (wr && paddr == `U1_OFS_RLL) begin
      nxt_bcfg.reload[7:0] = pwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ren_ff  <= 1'b0;
      ie_ff   <= 1'b0;
      tbx_ff  <= 1'b0;
      fmt_ff  <= `U1_RST_FMT;
      bcfg_ff <= {1'b0, `U1_PS_12, `U1_RST_RELOAD};
    end else begin
      ren_ff  <= nxt_ren;
      ie_ff   <= nxt_ie;
      tbx_ff  <= nxt_tbx;
      fmt_ff  <= nxt_fmt;
      bcfg_ff <= nxt_bcfg;
    end
  end

  // sticky flags: writing 0 clears, hardware set wins over the clear
  always_comb begin
    nxt_ri = ri_ff;
    nxt_ti = ti_ff;
    nxt_ovr = ovr_ff;
    // clear blocked while more than one byte is queued
    if (wr_scs && !pwdata[`U1_SCS_RI] && f_cnt <= CW'(1)) begin
      nxt_ri = 1'b0;
    end
    if (wr_scs && !pwdata[`U1_SCS_TI]) begin
      nxt_ti = 1'b0;
    end
    if (wr_scs && !pwdata[`U1_SCS_OVR]) begin
      nxt_ovr = 1'b0;
    end
    if (push) begin
      nxt_ri = 1'b1;
    end
    if (ti_set) begin
      nxt_ti = 1'b1;
    end
    if (ovr_set) begin
      nxt_ovr = 1'b1;
    end
    nxt_irq = ie_ff && (ri_ff || ti_ff);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ri_ff  <= 1'b0;
      ti_ff  <= 1'b0;
      ovr_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      ri_ff  <= nxt_ri;
      ti_ff  <= nxt_ti;
      ovr_ff <= nxt_ovr;
      irq_ff <= nxt_irq;
    end
  end

  u1_baud u_baud (
    .mclk (mclk),
    .nrst (nrst),
    .cfg  (bcfg_ff),
    .ovf  (ovf)
  );

  // transmitter; every bit spans two timer overflows
  always_comb begin
    nxt_thr      = thr_ff;
    nxt_thr_full = thr_full_ff;
    nxt_tx_st    = tx_st_ff;
    nxt_tx_sh    = tx_sh_ff;
    nxt_tx_cnt   = tx_cnt_ff;
    nxt_tx_ph    = tx_ph_ff;
    nxt_tx       = tx_ff;
    nxt_eb       = eb_ff;
    ti_set       = 1'b0;
    tx_load      = (tx_st_ff == TX_IDLE) && thr_full_ff;
    msk          = 8'hff >> (2'h3 - fmt_ff.len);
    if (wr && paddr == `U1_OFS_DATA) begin
      nxt_thr      = pwdata[7:0];
      nxt_thr_full = 1'b1;
    end
    if (ovf && tx_st_ff != TX_IDLE) begin
      nxt_tx_ph = !tx_ph_ff;
    end
    unique case (tx_st_ff)
      TX_IDLE: begin
        if (tx_load) begin
          // a data write landing on the load cycle stays held for the next frame
          nxt_thr_full = wr && (paddr == `U1_OFS_DATA);
          nxt_tx_sh    = thr_ff & msk;
          nxt_tx_st    = TX_SYNC;
          unique case (fmt_ff.ptype)
            2'b00: nxt_eb = ~^(thr_ff & msk);
            2'b01: nxt_eb = ^(thr_ff & msk);
            2'b10: nxt_eb = 1'b1;
            2'b11: nxt_eb = 1'b0;
          endcase
          if (!fmt_ff.pe) begin
            nxt_eb = tbx_ff;
          end
        end
      end
      // waits here while the generator is off
      TX_SYNC: if (ovf) begin
        nxt_tx_st = TX_START;
        nxt_tx    = 1'b0;
        nxt_tx_ph = 1'b0;
      end
      TX_START: if (ovf && tx_ph_ff) begin
        nxt_tx_st  = TX_DATA;
        nxt_tx     = tx_sh_ff[0];
        nxt_tx_cnt = 3'h0;
      end
      TX_DATA: if (ovf && tx_ph_ff) begin
        nxt_tx_sh  = tx_sh_ff >> 1;
        nxt_tx     = tx_sh_ff[1];
        nxt_tx_cnt = tx_cnt_ff + 3'h1;
        if (tx_cnt_ff == last) begin
          nxt_tx_cnt = 3'h0;
          nxt_tx_st  = (fmt_ff.pe || fmt_ff.xbe) ? TX_EXTRA : TX_STOP;
          nxt_tx     = (fmt_ff.pe || fmt_ff.xbe) ? eb_ff : 1'b1;
          ti_set     = !(fmt_ff.pe || fmt_ff.xbe);
        end
      end
      TX_EXTRA: if (ovf && tx_ph_ff) begin
        nxt_tx_st = TX_STOP;
        nxt_tx    = 1'b1;
        ti_set    = 1'b1;
      end
      TX_STOP: if (ovf && tx_ph_ff) begin
        nxt_tx_cnt = 3'h1;
        if (!fmt_ff.sb2 || tx_cnt_ff != 3'h0) begin
          nxt_tx_st = TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      thr_ff      <= 8'h00;
      thr_full_ff <= 1'b0;
      tx_st_ff    <= TX_IDLE;
      tx_sh_ff    <= 8'h00;
      tx_cnt_ff   <= 3'h0;
      tx_ph_ff    <= 1'b0;
      tx_ff       <= 1'b1;
      eb_ff       <= 1'b0;
    end else begin
      thr_ff      <= nxt_thr;
      thr_full_ff <= nxt_thr_full;
      tx_st_ff    <= nxt_tx_st;
      tx_sh_ff    <= nxt_tx_sh;
      tx_cnt_ff   <= nxt_tx_cnt;
      tx_ph_ff    <= nxt_tx_ph;
      tx_ff       <= nxt_tx;
      eb_ff       <= nxt_eb;
    end
  end

  // receiver; start is seen at an overflow, later bits sampled two overflows apart
  // limitation: the sample point lies 0 to half a bit into each bit
  always_comb begin
    nxt_rx_st  = rx_st_ff;
    nxt_rx_sh  = rx_sh_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_ph  = rx_ph_ff;
    rx_fin     = 1'b0;
    if (ovf && rx_st_ff != RX_IDLE) begin
      nxt_rx_ph = !rx_ph_ff;
    end
    unique case (rx_st_ff)
      RX_IDLE: if (ovf && ren_ff && !rx_s_ff) begin
        nxt_rx_st  = RX_DATA;
        nxt_rx_sh  = 8'h00;
        nxt_rx_cnt = 3'h0;
        nxt_rx_ph  = 1'b0;
      end
      RX_DATA: if (ovf && rx_ph_ff) begin
        nxt_rx_sh[rx_cnt_ff] = rx_s_ff;
        nxt_rx_cnt           = rx_cnt_ff + 3'h1;
        if (rx_cnt_ff == last) begin
          nxt_rx_st = (fmt_ff.pe || fmt_ff.xbe) ? RX_EXTRA : RX_STOP;
        end
      end
      RX_EXTRA: if (ovf && rx_ph_ff) begin
        nxt_rx_st = RX_STOP;
      end
      RX_STOP: if (ovf && rx_ph_ff) begin
        nxt_rx_st = RX_IDLE;
        rx_fin    = ren_ff && rx_s_ff;
      end
    endcase
  end

  assign push    = rx_fin && !f_full;
  assign ovr_set = rx_fin && f_full;
  assign pop     = rd && (paddr == `U1_OFS_DATA) && !f_empty;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_st_ff  <= RX_IDLE;
      rx_sh_ff  <= 8'h00;
      rx_cnt_ff <= 3'h0;
      rx_ph_ff  <= 1'b0;
    end else begin
      rx_st_ff  <= nxt_rx_st;
      rx_sh_ff  <= nxt_rx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_ph_ff  <= nxt_rx_ph;
    end
  end

  u1_rxfifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .mclk  (mclk),
    .nrst  (nrst),
    .push  (push),
    .din   (rx_sh_ff),
    .pop   (pop),
    .dout  (f_head),
    .cnt   (f_cnt),
    .full  (f_full),
    .empty (f_empty)
  );

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign uart_tx = tx_ff;
  assign irq     = irq_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_wr_thr;
    wr && paddr == `U1_OFS_DATA |=> thr_ff == $past(pwdata[7:0]) && thr_full_ff;
  endproperty
  a_wr_thr: assert property (p_wr_thr) else $error("data write missed holding reg");

  property p_rd_head;
    acc && !pready_ff && !pwrite && paddr == `U1_OFS_DATA |=> prdata[7:0] == $past(f_head);
  endproperty
  a_rd_head: assert property (p_rd_head) else $error("data read not fifo head");

  property p_over;
    rx_fin && f_full |=> ovr_ff && f_cnt == CW'(FIFO_DEPTH) - CW'($past(pop));
  endproperty
  a_over: assert property (p_over) else $error("overrun not flagged");

  property p_irq;
    ie_ff && (ri_ff || ti_ff) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_ti_sticky;
    ti_ff && !wr_scs |=> ti_ff;
  endproperty
  a_ti_sticky: assert property (p_ti_sticky) else $error("tx-done lost without clear");

  property p_ri_hold;
    ri_ff && wr_scs && !pwdata[`U1_SCS_RI] && f_cnt > CW'(1) |=> ri_ff;
  endproperty
  a_ri_hold: assert property (p_ri_hold) else $error("rx-ready cleared with bytes queued");

  property p_off_quiet;
    !bcfg_ff.en |=> $stable(uart_tx);
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("line moved with baud off");

  property p_ti_stop;
    tx_st_ff != TX_STOP ##1 tx_st_ff == TX_STOP |-> ti_ff && uart_tx;
  endproperty
  a_ti_stop: assert property (p_ti_stop) else $error("tx-done not set at stop");

  property p_pop;
    pop && !push |=> f_cnt == $past(f_cnt) - CW'(1);
  endproperty
  a_pop: assert property (p_pop) else $error("read did not free a slot");

  c_overrun: cover property (rx_fin && f_full);
  c_frame:   cover property (tx_st_ff == TX_STOP ##1 tx_st_ff == TX_IDLE);
  c_ri_blk:  cover property (ri_ff && wr_scs && !pwdata[`U1_SCS_RI] && f_cnt > CW'(1));

endmodule // u1_top
`default_nettype wire

/* File: verif/u1_peer.sv */
// serial partner: sends frames on uart_rx, captures frames from uart_tx
// assumes the bench gives the bit time in mclk cycles
`timescale 1ns/1ps
`default_nettype none
module u1_peer (
  // clock
  input  wire logic mclk,
  // serial line
  input  wire logic uart_tx,
  output logic      uart_rx
);
  // idle line rests high between frames
  initial uart_rx = 1'b1;
  // start low, lsb first, stop high
  task automatic send(input logic [7:0] b, input int bt);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      uart_rx <= f[i];
      repeat (bt) @(posedge mclk);
    end
  endtask
  // sample mid-bit, stop must be high
  task automatic recv(input int bt, output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    while (uart_tx !== 1'b0 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    repeat (bt / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bt) @(posedge mclk);
      b[i] = uart_tx;
    end
    repeat (bt) @(posedge mclk);
    ok = n < 5000 && uart_tx === 1'b1;
  endtask
endmodule // u1_peer
`default_nettype wire

/* File: verif/test_u1_top.sv */
// bench for the serial port: apb master, queue model, serial partner
// assumes u1_top on a 40 MHz mclk and u1_peer on the serial pins
`timescale 1ns/1ps
`default_nettype none
`include "u1_map.svh"
module test_u1_top;
  import u1_pkg::*;
  localparam logic [7:0] DAT = `U1_OFS_DATA, SCS = `U1_OFS_SCS, BGC = `U1_OFS_BGC;
  localparam logic [7:0] RLH = `U1_OFS_RLH, RLL = `U1_OFS_RLL;
  localparam logic [31:0] EN = 1 << `U1_BGC_EN, CTL = (1 << `U1_SCS_REN) | (1 << `U1_SCS_IE);
  // design pins
  logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, uart_rx, uart_tx, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  // bench state
  int          bad_count = 0, check_count = 0, cyc = 0, n;
  logic [31:0] seed, rd, d, t0, t1;
  logic        err, ok;
  logic [7:0]  b, rb;
  int          rxq[$];
  logic [7:0]  ofs[5] = '{SCS, `U1_OFS_FMT, BGC, RLH, RLL};
  logic [31:0] rv[5] = '{32'h04, 32'h03, 32'h00, 32'h00, 32'h00};
  logic [1:0]  ps[5] = '{`U1_PS_1, `U1_PS_4, `U1_PS_12, `U1_PS_48, `U1_PS_4};
  int          dv[5] = '{1, 4, 12, 48, 4};
  int          rl[5] = '{65535, 65535, 65535, 65535, 65533};

  u1_top i_u1_top (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .uart_rx(uart_rx), .uart_tx(uart_tx), .irq(irq));
  u1_peer i_u1_peer (.mclk(mclk), .uart_tx(uart_tx), .uart_rx(uart_rx));

  // 25 ns clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard, well above the longest test
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer, then one idle cycle so no signal is driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    if (k >= 50) chk("pready", 0, 1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, nrst} = '0;
    seed = 32'h3bd7;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    foreach (ofs[i]) begin
      apb(0, ofs[i], 0);
      chk("reset value", rd, rv[i]);
    end
    d = rnd();
    apb(1, RLH, d >> 8);
    apb(1, RLL, d);
    apb(0, RLH, 0);
    chk("reload high", rd, {24'h0, d[15:8]});
    apb(0, RLL, 0);
    chk("reload low", rd, {24'h0, d[7:0]});
    apb(0, 8'h3c, 0);
    chk("unmapped", {rd[30:0], err}, 1);
    $display("test registers done");
    // byte written with the generator off must not leave
    apb(1, DAT, 0);
    ok = 1'b1;
    repeat (40) @(posedge mclk) if (uart_tx !== 1'b1) ok = 1'b0;
    chk("idle while off", ok, 1);
    for (int i = 0; i < 5; i++) begin
      apb(1, RLL, rl[i]);
      apb(1, RLH, rl[i] >> 8);
      if (i > 0) apb(1, DAT, 0);
      apb(1, BGC, EN | ps[i]);
      n = 0;
      while (uart_tx !== 1'b0 && n < 9000) @(posedge mclk) n++;
      n = 0;
      while (uart_tx === 1'b0 && n < 9000) @(posedge mclk) n++;
      chk("low time", n, 18 * dv[i] * (65536 - rl[i]));
      repeat (2 * dv[i] * (65536 - rl[i]) + 4) @(posedge mclk);
      apb(1, BGC, 0);
    end
    $display("test prescaler done");
    apb(1, RLL, 32'hf8);
    apb(1, RLH, 32'hff);
    apb(1, BGC, EN | `U1_PS_1);
    apb(1, SCS, CTL);
    t0 = rnd();
    t1 = rnd();
    fork
      for (int i = 0; i < 4; i++) begin
        b = 8'(rnd());
        rxq.push_back(b);
        i_u1_peer.send(b, 16);
      end
      begin
        apb(1, DAT, t0);
        apb(0, SCS, 0);
        chk("holding empty", rd[`U1_SCS_THRE], 1);
        apb(1, DAT, t1);
        apb(0, SCS, 0);
        chk("holding full", rd[`U1_SCS_THRE], 0);
      end
      begin
        i_u1_peer.recv(16, rb, ok);
        chk("tx byte 0", {ok, rb}, {1'b1, t0[7:0]});
        i_u1_peer.recv(16, rb, ok);
        chk("tx byte 1", {ok, rb}, {1'b1, t1[7:0]});
      end
    join
    repeat (40) @(posedge mclk);
    chk("irq", irq, 1);
    apb(1, SCS, 32'h53);
    apb(0, SCS, 0);
    chk("flags kept", {rd[6], rd[1:0]}, 3'h7);
    chk("irq masked", irq, 0);
    for (int i = 0; i < 3; i++) begin
      apb(1, SCS, CTL);
      apb(0, SCS, 0);
      chk("rx ready", rd[`U1_SCS_RI], 3 - i >= 2);
      apb(0, DAT, 0);
      chk("rx byte", rd, rxq.pop_front());
    end
    // the fourth byte was dropped, so the fifo must now read empty
    apb(0, DAT, 0);
    chk("overflow dropped", rd, 0);
    chk("irq clear", irq, 0);
    $display("test duplex done");
    // seven data bits, even parity, two stop bits
    apb(1, `U1_OFS_FMT, 32'h4e);
    t0 = rnd();
    t1 = rnd();
    fork
      i_u1_peer.recv(16, rb, ok);
      begin
        apb(1, DAT, t0);
        apb(1, DAT, t1);
      end
    join
    chk("parity frame 0", {ok, rb}, {1'b1, ^t0[6:0], t0[6:0]});
    // second frame waits in holding: two stops plus one overflow before its start
    n = 0;
    while (uart_tx !== 1'b0 && n < 9000) @(posedge mclk) n++;
    chk("two stop bits", n, 32);
    i_u1_peer.recv(16, rb, ok);
    chk("parity frame 1", {ok, rb}, {1'b1, ^t1[6:0], t1[6:0]});
    $display("test format done");
    give_verdict();
  end
endmodule // test_u1_top
`default_nettype wire
